/* File: core/tim_oc_pkg.sv */
// Constants and types of the compare/PWM output stage
package tim_oc_pkg;
   localparam int CW = 16;
   localparam int AW = 8;
   // Register byte offsets
   localparam logic [AW-1:0] OFS_CTL1 = 8'h00;
   localparam logic [AW-1:0] OFS_CTL2 = 8'h04;
   localparam logic [AW-1:0] OFS_IEN  = 8'h0C;
   localparam logic [AW-1:0] OFS_STAT = 8'h10;
   localparam logic [AW-1:0] OFS_EGEN = 8'h14;
   localparam logic [AW-1:0] OFS_CMOD = 8'h18;
   localparam logic [AW-1:0] OFS_CENA = 8'h20;
   localparam logic [AW-1:0] OFS_CNT  = 8'h24;
   localparam logic [AW-1:0] OFS_ARR  = 8'h2C;
   localparam logic [AW-1:0] OFS_CCR  = 8'h34;
   // Field positions
   localparam int B_CEN  = 0;
   localparam int B_DIR  = 4;
   localparam int B_CMS  = 5;
   localparam int B_AUTO_RELOAD_PRELOAD_ENABLE = 7;
   localparam int B_DMA_REQUEST_SELECT = 3;
   localparam int B_UIE  = 0;
   localparam int B_CCIE = 1;
   localparam int B_CCDE = 9;
   localparam int B_UIF  = 0;
   localparam int B_CCIF = 1;
   localparam int B_UG   = 0;
   localparam int B_SEL  = 0;
   localparam int B_OCPE = 3;
   localparam int B_OCM  = 4;
   localparam int B_OCCE = 7;
   localparam int B_CCE  = 0;
   localparam int B_CCP  = 1;
   // Compare modes
   localparam logic [2:0] M_FROZEN = 3'h0;
   localparam logic [2:0] M_SET    = 3'h1;
   localparam logic [2:0] M_CLR    = 3'h2;
   localparam logic [2:0] M_TOG    = 3'h3;
   localparam logic [2:0] M_FLOW   = 3'h4;
   localparam logic [2:0] M_FHIGH  = 3'h5;
   localparam logic [2:0] M_PWM1   = 3'h6;
   localparam logic [2:0] M_PWM2   = 3'h7;
   // Center mode values
   localparam logic [1:0] CM_EDGE = 2'h0;
   localparam logic [1:0] CM_DOWN = 2'h1;
   localparam logic [1:0] CM_UP   = 2'h2;

   typedef struct packed {
      logic          psel;
      logic          penable;
      logic          pwrite;
      logic [AW-1:0] paddr;
      logic [31:0]   pwdata;
   } apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic [CW-1:0] auto_reload_value;
      logic [CW-1:0] arr_sh;
      logic [CW-1:0] ccr;
      logic [CW-1:0] ccr_sh;
      logic          counter_enable_bit;
      logic          dir;
      logic [1:0]    center_mode_field;
      logic          auto_reload_preload_enable;
      logic          dma_request_select;
      logic          uie;
      logic          ccie;
      logic          ccde;
      logic          uif;
      logic          ccif;
      logic [1:0]    sel;
      logic          ocpe;
      logic [2:0]    ocm;
      logic [2:0]    ocm_prev;
      logic          occe;
      logic          cce;
      logic          ccp;
      logic          ref_sig;
      logic          raw_prev;
      logic          clr;
      logic          ext_s1;
      logic          ext_s2;
      logic          ext_s3;
      logic          pin;
      logic          pin_oe_n;
      logic          irq;
      logic          dma;
      apb_rsp_t      rsp;
   } st_t;

   localparam st_t ST_RST = '{pin_oe_n: 1'b1, default: '0};
endpackage

/* File: core/timer_output_compare_pwm.sv */
// Compare/PWM output stage with counter and APB register file
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module timer_output_compare_pwm
(
   input  wire logic                 mclk_i,
   input  wire logic                 srst_i,
   input  wire tim_oc_pkg::apb_req_t apb_i,
   output var  tim_oc_pkg::apb_rsp_t apb_o,
   input  wire logic                 ext_trig_i,
   output logic                      pin_o,
   output logic                      pin_oe_n_o,
   output logic                      irq_o,
   output logic                      dma_req_o
);
   tim_oc_pkg::st_t s_ff;
   tim_oc_pkg::st_t nxt_s;

   always_comb
   begin
      logic                        wr;
      logic                        setup;
      logic                        update_event;
      logic                        match;
      logic                        flag_ok;
      logic                        pwm;
      logic                        raw;
      logic                        ext_ev;
      logic [tim_oc_pkg::CW-1:0]   arr_use;
      logic [tim_oc_pkg::CW-1:0]   ccr_use;
      logic [31:0]                 rd;
      logic                        hit;
      logic [31:0]                 d;
      nxt_s   = s_ff;
      d       = apb_i.pwdata;
      setup   = apb_i.psel & ~apb_i.penable;
      wr      = apb_i.psel & apb_i.penable & apb_i.pwrite & s_ff.rsp.pready;
      update_event     = 1'b0;
      match   = 1'b0;
      rd      = 32'h0000_0000;
      hit     = 1'b1;
      arr_use = s_ff.auto_reload_preload_enable ? s_ff.arr_sh : s_ff.auto_reload_value;
      ccr_use = s_ff.ocpe ? s_ff.ccr_sh : s_ff.ccr;
      pwm     = (s_ff.ocm == tim_oc_pkg::M_PWM1) | (s_ff.ocm == tim_oc_pkg::M_PWM2);

      // Trigger synchroniser and edge
      nxt_s.ext_s1 = ext_trig_i;
      nxt_s.ext_s2 = s_ff.ext_s1;
      nxt_s.ext_s3 = s_ff.ext_s2;
      ext_ev       = s_ff.ext_s2 & ~s_ff.ext_s3;

      if (s_ff.counter_enable_bit && s_ff.cnt == ccr_use)
      begin
         match = 1'b1;
      end

      // Counter stepping
      if (s_ff.counter_enable_bit)
      begin
         if (s_ff.center_mode_field == tim_oc_pkg::CM_EDGE)
         begin
            if (!s_ff.dir)
            begin
               if (s_ff.cnt == arr_use)
               begin
                  nxt_s.cnt = '0;
                  update_event       = 1'b1;
               end
               else
               begin
                  nxt_s.cnt = s_ff.cnt + 16'h0001;
               end
            end
            else
            begin
               if (s_ff.cnt == 16'h0000)
               begin
                  nxt_s.cnt = arr_use;
                  update_event       = 1'b1;
               end
               else
               begin
                  nxt_s.cnt = s_ff.cnt - 16'h0001;
               end
            end
         end
         else
         begin
            if (!s_ff.dir)
            begin
               nxt_s.cnt = s_ff.cnt + 16'h0001;
               if (s_ff.cnt + 16'h0001 == arr_use)
               begin
                  nxt_s.dir = 1'b1;
                  update_event       = 1'b1;
               end
            end
            else
            begin
               nxt_s.cnt = s_ff.cnt - 16'h0001;
               if (s_ff.cnt == 16'h0001)
               begin
                  nxt_s.dir = 1'b0;
                  update_event       = 1'b1;
               end
            end
         end
      end

      case (s_ff.center_mode_field)
         tim_oc_pkg::CM_EDGE: flag_ok = 1'b1;
         tim_oc_pkg::CM_DOWN: flag_ok = s_ff.dir;
         tim_oc_pkg::CM_UP:   flag_ok = ~s_ff.dir;
         default:             flag_ok = 1'b1;
      endcase
      match = match & flag_ok;

      // Register writes at access edge
      if (wr)
      begin
         if (apb_i.paddr == tim_oc_pkg::OFS_CTL1)
         begin
            nxt_s.counter_enable_bit  = d[tim_oc_pkg::B_CEN];
            nxt_s.center_mode_field  = d[tim_oc_pkg::B_CMS+:2];
            nxt_s.auto_reload_preload_enable = d[tim_oc_pkg::B_AUTO_RELOAD_PRELOAD_ENABLE];
            // Direction written only in edge mode or when stopped
            if (s_ff.center_mode_field == tim_oc_pkg::CM_EDGE || !s_ff.counter_enable_bit)
            begin
               nxt_s.dir = d[tim_oc_pkg::B_DIR];
            end
         end
         else if (apb_i.paddr == tim_oc_pkg::OFS_CTL2)
         begin
            nxt_s.dma_request_select = d[tim_oc_pkg::B_DMA_REQUEST_SELECT];
         end
         else if (apb_i.paddr == tim_oc_pkg::OFS_IEN)
         begin
            nxt_s.uie  = d[tim_oc_pkg::B_UIE];
            nxt_s.ccie = d[tim_oc_pkg::B_CCIE];
            nxt_s.ccde = d[tim_oc_pkg::B_CCDE];
         end
         else if (apb_i.paddr == tim_oc_pkg::OFS_STAT)
         begin
            nxt_s.uif  = s_ff.uif & d[tim_oc_pkg::B_UIF];
            nxt_s.ccif = s_ff.ccif & d[tim_oc_pkg::B_CCIF];
         end
         else if (apb_i.paddr == tim_oc_pkg::OFS_EGEN)
         begin
            if (d[tim_oc_pkg::B_UG])
            begin
               update_event       = 1'b1;
               nxt_s.cnt = (s_ff.center_mode_field == tim_oc_pkg::CM_EDGE && s_ff.dir) ? s_ff.auto_reload_value : '0;
            end
         end
         else if (apb_i.paddr == tim_oc_pkg::OFS_CMOD)
         begin
            nxt_s.sel  = d[tim_oc_pkg::B_SEL+:2];
            nxt_s.ocpe = d[tim_oc_pkg::B_OCPE];
            nxt_s.ocm  = d[tim_oc_pkg::B_OCM+:3];
            nxt_s.occe = d[tim_oc_pkg::B_OCCE];
         end
         else if (apb_i.paddr == tim_oc_pkg::OFS_CENA)
         begin
            nxt_s.cce = d[tim_oc_pkg::B_CCE];
            nxt_s.ccp = d[tim_oc_pkg::B_CCP];
         end
         else if (apb_i.paddr == tim_oc_pkg::OFS_CNT)
         begin
            nxt_s.cnt = d[tim_oc_pkg::CW-1:0];
            if (s_ff.center_mode_field != tim_oc_pkg::CM_EDGE)
            begin
               if (d[tim_oc_pkg::CW-1:0] == 16'h0000)
               begin
                  nxt_s.dir = 1'b0;
               end
               else if (d[tim_oc_pkg::CW-1:0] == arr_use)
               begin
                  nxt_s.dir = 1'b1;
               end
               update_event = 1'b0;
            end
         end
         else if (apb_i.paddr == tim_oc_pkg::OFS_ARR)
         begin
            nxt_s.auto_reload_value = d[tim_oc_pkg::CW-1:0];
         end
         else if (apb_i.paddr == tim_oc_pkg::OFS_CCR)
         begin
            nxt_s.ccr = d[tim_oc_pkg::CW-1:0];
         end
      end

      if (update_event)
      begin
         nxt_s.arr_sh = nxt_s.auto_reload_value;
         nxt_s.ccr_sh = nxt_s.ccr;
      end

      if (match)
      begin
         nxt_s.ccif = 1'b1;
      end
      if (update_event)
      begin
         nxt_s.uif = 1'b1;
      end

      nxt_s.irq = (nxt_s.ccif & s_ff.ccie) | (nxt_s.uif & s_ff.uie);
      nxt_s.dma = s_ff.ccde & (s_ff.dma_request_select ? update_event : match);

      raw = s_ff.cnt < ccr_use;
      if (s_ff.dir)
      begin
         raw = s_ff.cnt <= ccr_use;
      end
      if (s_ff.ocm == tim_oc_pkg::M_PWM2)
      begin
         raw = ~raw;
      end
      nxt_s.raw_prev = raw;
      nxt_s.ocm_prev = s_ff.ocm;

      if (update_event)
      begin
         nxt_s.clr = 1'b0;
      end
      if (ext_ev && s_ff.occe && pwm)
      begin
         nxt_s.clr = 1'b1;
      end

      // Reference generation
      case (s_ff.ocm)
         tim_oc_pkg::M_SET:
         begin
            if (match)
            begin
               nxt_s.ref_sig = 1'b1;
            end
         end
         tim_oc_pkg::M_CLR:
         begin
            if (match)
            begin
               nxt_s.ref_sig = 1'b0;
            end
         end
         tim_oc_pkg::M_TOG:
         begin
            if (match)
            begin
               nxt_s.ref_sig = ~s_ff.ref_sig;
            end
         end
         tim_oc_pkg::M_FLOW:  nxt_s.ref_sig = 1'b0;
         tim_oc_pkg::M_FHIGH: nxt_s.ref_sig = 1'b1;
         tim_oc_pkg::M_PWM1,
         tim_oc_pkg::M_PWM2:
         begin
            // Assign on change, from frozen or at update event
            if (nxt_s.clr)
            begin
               nxt_s.ref_sig = 1'b0;
            end
            else if (raw != s_ff.raw_prev || s_ff.ocm_prev == tim_oc_pkg::M_FROZEN || update_event)
            begin
               nxt_s.ref_sig = raw;
            end
         end
         default: nxt_s.ref_sig = s_ff.ref_sig;
      endcase

      nxt_s.pin_oe_n = ~(s_ff.cce & (s_ff.sel == 2'h0));
      nxt_s.pin      = s_ff.cce & (s_ff.sel == 2'h0) & (nxt_s.ref_sig ^ s_ff.ccp);

      // Read mux
      if (apb_i.paddr == tim_oc_pkg::OFS_CTL1)
      begin
         rd[tim_oc_pkg::B_CEN]     = s_ff.counter_enable_bit;
         rd[tim_oc_pkg::B_DIR]     = s_ff.dir;
         rd[tim_oc_pkg::B_CMS+:2]  = s_ff.center_mode_field;
         rd[tim_oc_pkg::B_AUTO_RELOAD_PRELOAD_ENABLE]    = s_ff.auto_reload_preload_enable;
      end
      else if (apb_i.paddr == tim_oc_pkg::OFS_CTL2)
      begin
         rd[tim_oc_pkg::B_DMA_REQUEST_SELECT]    = s_ff.dma_request_select;
      end
      else if (apb_i.paddr == tim_oc_pkg::OFS_IEN)
      begin
         rd[tim_oc_pkg::B_UIE]     = s_ff.uie;
         rd[tim_oc_pkg::B_CCIE]    = s_ff.ccie;
         rd[tim_oc_pkg::B_CCDE]    = s_ff.ccde;
      end
      else if (apb_i.paddr == tim_oc_pkg::OFS_STAT)
      begin
         rd[tim_oc_pkg::B_UIF]     = s_ff.uif;
         rd[tim_oc_pkg::B_CCIF]    = s_ff.ccif;
      end
      else if (apb_i.paddr == tim_oc_pkg::OFS_EGEN)
      begin
         rd = 32'h0000_0000;
      end
      else if (apb_i.paddr == tim_oc_pkg::OFS_CMOD)
      begin
         rd[tim_oc_pkg::B_SEL+:2]  = s_ff.sel;
         rd[tim_oc_pkg::B_OCPE]    = s_ff.ocpe;
         rd[tim_oc_pkg::B_OCM+:3]  = s_ff.ocm;
         rd[tim_oc_pkg::B_OCCE]    = s_ff.occe;
      end
      else if (apb_i.paddr == tim_oc_pkg::OFS_CENA)
      begin
         rd[tim_oc_pkg::B_CCE]     = s_ff.cce;
         rd[tim_oc_pkg::B_CCP]     = s_ff.ccp;
      end
      else if (apb_i.paddr == tim_oc_pkg::OFS_CNT)
      begin
         rd[tim_oc_pkg::CW-1:0]    = s_ff.cnt;
      end
      else if (apb_i.paddr == tim_oc_pkg::OFS_ARR)
      begin
         rd[tim_oc_pkg::CW-1:0]    = s_ff.auto_reload_value;
      end
      else if (apb_i.paddr == tim_oc_pkg::OFS_CCR)
      begin
         rd[tim_oc_pkg::CW-1:0]    = s_ff.ccr;
      end
      else
      begin
         hit = 1'b0;
      end

      // APB answer: ready in first access cycle
      nxt_s.rsp.pready  = setup;
      nxt_s.rsp.pslverr = setup & ~hit;
      if (setup)
      begin
         nxt_s.rsp.prdata  = apb_i.pwrite ? 32'h0000_0000 : rd;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         s_ff <= tim_oc_pkg::ST_RST;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign apb_o      = s_ff.rsp;
   assign pin_o      = s_ff.pin;
   assign pin_oe_n_o = s_ff.pin_oe_n;
   assign irq_o      = s_ff.irq;
   assign dma_req_o  = s_ff.dma;
endmodule
`default_nettype wire

/* File: tb/timer_output_compare_pwm_monitor.sv */
// Port checker of the compare/PWM output stage
`timescale 1ns/100ps
`default_nettype none
module timer_output_compare_pwm_monitor
(
   input wire logic                 mclk_i,
   input wire logic                 srst_i,
   input wire tim_oc_pkg::apb_req_t apb_i,
   input wire tim_oc_pkg::apb_rsp_t apb_o,
   input wire logic                 ext_trig_i,
   input wire logic                 pin_o,
   input wire logic                 pin_oe_n_o,
   input wire logic                 irq_o,
   input wire logic                 dma_req_o
);
   logic       wr;
   logic       q_ff;
   logic       en_ff;
   logic       pol_ff;
   logic [1:0] sel_ff;
   logic [2:0] mode_ff;
   logic [1:0] ie_ff;
   logic       ok;
   assign wr = apb_i.psel & apb_i.penable & apb_o.pready & apb_i.pwrite;
   assign ok = q_ff & en_ff & (sel_ff == 2'h0);
   // Shadow of the write traffic
   always_ff @(posedge mclk_i)
   begin
      q_ff <= ~wr & ~srst_i;
      if (srst_i)
      begin
         {en_ff, pol_ff, sel_ff, mode_ff, ie_ff} <= '0;
      end
      else if (wr && apb_i.paddr == tim_oc_pkg::OFS_CENA)
      begin
         {pol_ff, en_ff} <= apb_i.pwdata[1:0];
      end
      else if (wr && apb_i.paddr == tim_oc_pkg::OFS_CMOD)
      begin
         {mode_ff, sel_ff} <= {apb_i.pwdata[6:4], apb_i.pwdata[1:0]};
      end
      else if (wr && apb_i.paddr == tim_oc_pkg::OFS_IEN)
      begin
         ie_ff <= apb_i.pwdata[1:0];
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   sequence setup_s;
      apb_i.psel && !apb_i.penable;
   endsequence
   sequence answer_s;
      apb_o.pready ##1 !apb_o.pready;
   endsequence
   rdy_time_a: assert property (setup_s |=> answer_s) else $error("bus answer late");
   err_pair_a: assert property (apb_o.pslverr |-> apb_o.pready) else $error("stray bus error");
   oe_off_a: assert property (pin_oe_n_o |-> !pin_o) else $error("pin high undriven");
   oe_on_a: assert property (ok |-> !pin_oe_n_o) else $error("pin not driven");
   force_hi_a: assert property (ok && mode_ff == tim_oc_pkg::M_FHIGH |-> pin_o == !pol_ff)
      else $error("forced high wrong");
   force_lo_a: assert property (ok && mode_ff == tim_oc_pkg::M_FLOW |-> pin_o == pol_ff)
      else $error("forced low wrong");
   frozen_hold_a: assert property (q_ff && $past(q_ff) && mode_ff == 3'h0 |-> $stable(pin_o))
      else $error("frozen pin moved");
   dma_pulse_a: assert property (dma_req_o |=> !dma_req_o) else $error("dma pulse long");
   irq_mask_a: assert property (q_ff && ie_ff == 2'h0 |-> !irq_o) else $error("masked irq");
endmodule
bind timer_output_compare_pwm timer_output_compare_pwm_monitor u_timer_output_compare_pwm_monitor
(.mclk_i, .srst_i, .apb_i, .apb_o, .ext_trig_i, .pin_o, .pin_oe_n_o, .irq_o, .dma_req_o);
`default_nettype wire

/* File: tb/timer_output_compare_pwm_tb.sv */
// Self-checking bench of the compare/PWM output stage
`timescale 1ns/100ps
`default_nettype none
module timer_output_compare_pwm_tb;
   logic                 mclk_i = 1'h0;
   logic                 srst_i = 1'h1;
   tim_oc_pkg::apb_req_t apb_i = '0;
   tim_oc_pkg::apb_rsp_t apb_o;
   logic                 ext_trig_i = 1'h0;
   logic                 pin_o;
   logic                 pin_oe_n_o;
   logic                 irq_o;
   logic                 dma_req_o;
   int                   miscompares = 0;
   int                   samples_checked = 0;
   int                   cycles = 0;
   int                   dmas = 0;
   logic [32:0]          exp_q[$];
   logic [31:0]          seed = 32'h000060C4;
   always #50 mclk_i = ~mclk_i;
   timer_output_compare_pwm u_timer_output_compare_pwm
   (.mclk_i, .srst_i, .apb_i, .apb_o, .ext_trig_i, .pin_o, .pin_oe_n_o, .irq_o, .dma_req_o);
   function automatic logic [31:0] rnd(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(input logic [32:0] got, input logic [32:0] want);
      samples_checked++;
      if (got !== want)
      begin
         miscompares++;
         $display("Error t=%0t got %0h exp %0h", $time, got, want);
      end
   endtask
   task automatic test_done;
      $display("Checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      apb_i <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
      @(posedge mclk_i);
      apb_i.penable <= 1'h1;
      @(posedge mclk_i);
      while (apb_o.pready !== 1'h1) @(posedge mclk_i);
      apb_i <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'h1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      xfer(1'h0, a, 32'h0);
   endtask
   task automatic pchk(input logic [1:0] e);
      repeat (3) @(negedge mclk_i);
      chk({pin_oe_n_o, pin_o}, e);
   endtask
   task automatic hi(input int n, output int c);
      c = 0;
      repeat (n) @(negedge mclk_i) c += (pin_o === 1'h1);
   endtask
   // Read scoreboard and timeout
   always @(posedge mclk_i)
   begin
      cycles++;
      if (dma_req_o === 1'h1) dmas++;
      if (apb_o.pready === 1'h1 && !apb_i.pwrite && exp_q.size() > 0)
         chk({apb_o.pslverr, apb_o.prdata}, exp_q.pop_front());
      if (cycles == 5000)
      begin
         miscompares++;
         test_done();
      end
   end
   initial
   begin
      int   c;
      int   i;
      int   m;
      int   r;
      logic p;
      repeat (2) @(posedge mclk_i);
      srst_i <= 1'h0;
      rd(tim_oc_pkg::OFS_CTL1, 33'h0);
      rd(tim_oc_pkg::OFS_STAT, 33'h0);
      rd(8'h08, 33'h100000000);
      pchk(2'h2);
      wr(tim_oc_pkg::OFS_ARR, 32'h9);
      wr(tim_oc_pkg::OFS_CCR, 32'h3);
      wr(tim_oc_pkg::OFS_CENA, 32'h1);
      wr(tim_oc_pkg::OFS_CMOD, 32'h50);
      pchk(2'h1);
      wr(tim_oc_pkg::OFS_CENA, 32'h3);
      pchk(2'h0);
      wr(tim_oc_pkg::OFS_CMOD, 32'h40);
      pchk(2'h1);
      wr(tim_oc_pkg::OFS_CENA, 32'h1);
      wr(tim_oc_pkg::OFS_IEN, 32'h202);
      wr(tim_oc_pkg::OFS_CTL1, 32'h1);
      @(negedge mclk_i);
      dmas = 0;
      repeat (20) @(negedge mclk_i);
      chk(33'(dmas), 33'h2);
      chk(irq_o, 33'h1);
      wr(tim_oc_pkg::OFS_CTL1, 32'h0);
      rd(tim_oc_pkg::OFS_STAT, 33'h3);
      wr(tim_oc_pkg::OFS_STAT, 32'h0);
      wr(tim_oc_pkg::OFS_IEN, 32'h0);
      rd(tim_oc_pkg::OFS_STAT, 33'h0);
      chk(irq_o, 33'h0);
      wr(tim_oc_pkg::OFS_CTL1, 32'h1);
      for (i = 1; i < 3; i++)
      begin
         wr(tim_oc_pkg::OFS_CMOD, 32'(i << 4));
         repeat (12) @(negedge mclk_i);
         pchk(2'(i == 1));
      end
      wr(tim_oc_pkg::OFS_CMOD, 32'h30);
      @(negedge mclk_i);
      p = pin_o;
      while (pin_o === p) @(negedge mclk_i);
      p = pin_o;
      c = 0;
      while (pin_o === p)
      begin
         @(negedge mclk_i);
         c++;
      end
      chk(33'(c), 33'hA);
      for (m = 0; m < 2; m++)
      begin
         for (i = 0; i < 3; i++)
         begin
            seed = rnd(seed);
            r = int'(seed % 11);
            wr(tim_oc_pkg::OFS_CMOD, m ? 32'h78 : 32'h68);
            wr(tim_oc_pkg::OFS_CCR, 32'(r));
            wr(tim_oc_pkg::OFS_EGEN, 32'h1);
            repeat (12) @(negedge mclk_i);
            hi(20, c);
            chk(33'(c), 33'(m ? 20 - 2 * r : 2 * r));
         end
      end
      wr(tim_oc_pkg::OFS_CMOD, 32'h68);
      wr(tim_oc_pkg::OFS_CTL1, 32'h11);
      for (i = 0; i < 2; i++)
      begin
         wr(tim_oc_pkg::OFS_CCR, 32'(4 - 4 * i));
         wr(tim_oc_pkg::OFS_EGEN, 32'h1);
         repeat (12) @(negedge mclk_i);
         hi(20, c);
         chk(33'(c), i ? 33'h2 : 33'hA);
      end
      wr(tim_oc_pkg::OFS_CTL1, 32'h1);
      wr(tim_oc_pkg::OFS_ARR, 32'h31);
      wr(tim_oc_pkg::OFS_CCR, 32'h3C);
      wr(tim_oc_pkg::OFS_CMOD, 32'hE8);
      wr(tim_oc_pkg::OFS_EGEN, 32'h1);
      wr(tim_oc_pkg::OFS_CNT, 32'h0);
      @(posedge mclk_i);
      ext_trig_i <= 1'h1;
      @(posedge mclk_i);
      ext_trig_i <= 1'h0;
      repeat (4) @(negedge mclk_i);
      pchk(2'h0);
      repeat (60) @(negedge mclk_i);
      pchk(2'h1);
      wr(tim_oc_pkg::OFS_CTL1, 32'h0);
      wr(tim_oc_pkg::OFS_EGEN, 32'h1);
      wr(tim_oc_pkg::OFS_CNT, 32'h5);
      wr(tim_oc_pkg::OFS_STAT, 32'h0);
      wr(tim_oc_pkg::OFS_CTL1, 32'h21);
      wr(tim_oc_pkg::OFS_CNT, 32'h31);
      rd(tim_oc_pkg::OFS_CTL1, 33'h31);
      rd(tim_oc_pkg::OFS_STAT, 33'h0);
      wr(tim_oc_pkg::OFS_CNT, 32'h40);
      rd(tim_oc_pkg::OFS_CTL1, 33'h31);
      wr(tim_oc_pkg::OFS_CTL1, 32'h21);
      rd(tim_oc_pkg::OFS_CTL1, 33'h31);
      wr(tim_oc_pkg::OFS_CTL1, 32'h20);
      wr(tim_oc_pkg::OFS_CMOD, 32'h60);
      wr(tim_oc_pkg::OFS_CCR, 32'h10);
      wr(tim_oc_pkg::OFS_CNT, 32'h8);
      wr(tim_oc_pkg::OFS_STAT, 32'h0);
      wr(tim_oc_pkg::OFS_CTL1, 32'h21);
      repeat (20) @(negedge mclk_i);
      rd(tim_oc_pkg::OFS_STAT, 33'h0);
      wr(tim_oc_pkg::OFS_CTL1, 32'h20);
      wr(tim_oc_pkg::OFS_CNT, 32'h20);
      wr(tim_oc_pkg::OFS_CTL1, 32'h31);
      repeat (20) @(negedge mclk_i);
      rd(tim_oc_pkg::OFS_STAT, 33'h2);
      test_done();
   end
endmodule
`default_nettype wire
